// File: hdl/pia_pkg.sv
// Constants and types for the priority interrupt acceptance block
package pia_pkg;
   localparam int          NUM_SRC_DEF     = 24;
   localparam int          STACK_DEPTH_DEF = 16;
   localparam int          SRC_PER_REG     = 4;
   localparam logic [1:0]  LEVEL_NONE      = 2'h3;
   localparam logic [7:0]  LEVEL_RST       = 8'hff;
   localparam logic [7:0]  ADR_LEVEL_BASE  = 8'h00;
   localparam logic [7:0]  ADR_FLAG        = 8'h40;
   localparam logic [7:0]  ADR_ENABLE      = 8'h44;
   localparam logic [7:0]  ADR_CCR         = 8'h48;
   localparam logic [7:0]  ADR_STATUS      = 8'h4c;
   localparam int          CCR_IL_LSB      = 0;
   localparam int          CCR_IEN_BIT     = 4;
   localparam logic [7:0]  CCR_MASK        = 8'h13;
   localparam logic [7:0]  CCR_RST         = 8'h03;
   localparam int          ENTRY_CYCLES    = 9;
   localparam int          DIVIDE_CYCLES   = 17;
   localparam int          MAX_LATENCY     = DIVIDE_CYCLES + ENTRY_CYCLES;
   localparam logic [15:0] VECTOR_TOP_DEF  = 16'hfffc;
   localparam logic [15:0] VECTOR_STEP     = 16'h0002;

   typedef enum logic [1:0] {
      PIA_IDLE,
      PIA_ENTRY,
      PIA_POP_PS,
      PIA_POP_PC
   } pia_state_e;
endpackage : pia_pkg

// File: hdl/pia_ctrl.sv
// Interrupt controller with CPU-side acceptance, entry, return and wake logic
`timescale 1ns/100ps
module pia_ctrl #(
   parameter int          NUM_SRC     = pia_pkg::NUM_SRC_DEF,
   parameter int          STACK_DEPTH = pia_pkg::STACK_DEPTH_DEF,
   parameter logic [15:0] VECTOR_TOP  = pia_pkg::VECTOR_TOP_DEF
) (
   input  wire logic               clk_i,
   input  wire logic               rst_i,
   input  wire logic               ce_i,
   input  wire logic               wb_cyc_i,
   input  wire logic               wb_stb_i,
   input  wire logic               wb_we_i,
   input  wire logic [7:0]         wb_adr_i,
   input  wire logic [3:0]         wb_sel_i,
   input  wire logic [31:0]        wb_dat_i,
   output logic      [31:0]        wb_dat_o,
   output logic                    wb_ack_o,
   input  wire logic [NUM_SRC-1:0] src_event_i,
   input  wire logic               instr_end_i,
   input  wire logic [15:0]        pc_i,
   input  wire logic               ret_i,
   input  wire logic               standby_i,
   output logic      [1:0]         irq_level_o,
   output logic                    entry_busy_o,
   output logic                    entry_done_o,
   output logic      [15:0]        vector_addr_o,
   output logic      [15:0]        pc_o,
   output logic                    resume_o,
   output logic                    wake_o
);
   localparam int IDX_W   = (NUM_SRC > 1) ? $clog2(NUM_SRC) : 1;
   localparam int SP_W    = $clog2(STACK_DEPTH);
   localparam int NUM_REG = NUM_SRC / pia_pkg::SRC_PER_REG;
   localparam logic [3:0]      ENTRY_LAST = 4'(pia_pkg::ENTRY_CYCLES - 1);
   localparam logic [SP_W-1:0] SP_TOP     = SP_W'(STACK_DEPTH - 1);

   if (NUM_SRC < 4 || NUM_SRC > 32 || (NUM_SRC % 4) != 0 || STACK_DEPTH < 4 || STACK_DEPTH > 256
       || (STACK_DEPTH & (STACK_DEPTH - 1)) != 0) begin : g_param_check
      $error("pia_ctrl: unsupported NUM_SRC or STACK_DEPTH");
   end

   logic [8*NUM_REG-1:0]  src_levels;
   logic [NUM_SRC-1:0]    req_flag;
   logic [NUM_SRC-1:0]    req_en;
   logic [7:0]            condition_code_reg;
   pia_pkg::pia_state_e   state;
   logic [3:0]            entry_cnt;
   logic [SP_W-1:0]       sp;
   logic [15:0]           stack_mem [0:STACK_DEPTH-1];
   logic [15:0]           saved_pc;
   logic [1:0]            acc_level;
   logic [IDX_W-1:0]      acc_idx;
   logic                  stack_err;
   logic [1:0]            best_level;
   logic [IDX_W-1:0]      best_idx;
   logic [1:0]            eff_level [0:NUM_SRC-1];

   // Register bus decode; writes commit on the edge where ack is high
   wire                   bus_req     = wb_cyc_i & wb_stb_i;
   wire                   bus_wr      = bus_req & wb_we_i & wb_ack_o;
   wire                   hit_level   = (wb_adr_i[1:0] == 2'h0) &&
                                        (wb_adr_i < (pia_pkg::ADR_LEVEL_BASE + 8'(4 * NUM_REG)));
   wire                   hit_flag    = (wb_adr_i == pia_pkg::ADR_FLAG);
   wire                   hit_enable  = (wb_adr_i == pia_pkg::ADR_ENABLE);
   wire                   hit_ccr     = (wb_adr_i == pia_pkg::ADR_CCR);
   wire                   hit_status  = (wb_adr_i == pia_pkg::ADR_STATUS);
   wire [3:0]             level_sel   = 4'(wb_adr_i[7:2] - pia_pkg::ADR_LEVEL_BASE[7:2]);
   wire [31:0]            lane_mask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   wire [NUM_SRC-1:0]     wr_mask     = lane_mask[NUM_SRC-1:0];
   wire [NUM_SRC-1:0]     flag_clr    = (bus_wr && hit_flag) ? (wr_mask & ~wb_dat_i[NUM_SRC-1:0]) : '0;
   wire                   ccr_sw_wr   = bus_wr && hit_ccr && wb_sel_i[0];

   wire [1:0]             cur_level   = condition_code_reg[pia_pkg::CCR_IL_LSB +: 2];
   wire                   glob_en     = condition_code_reg[pia_pkg::CCR_IEN_BIT];
   wire                   any_pend    = (best_level != pia_pkg::LEVEL_NONE);
   // Sampled in the last instruction cycle only; the less-than also keeps level 3 out
   wire                   accept      = (state == pia_pkg::PIA_IDLE) && instr_end_i && glob_en &&
                                        (best_level < cur_level);
   // A call during entry or return is dropped; the core only returns from a running service
   wire                   ret_start   = (state == pia_pkg::PIA_IDLE) && ret_i && !instr_end_i;
   // Only PC and status go on the stack; accumulators stay with software
   wire                   push_en     = (state == pia_pkg::PIA_ENTRY) && (entry_cnt < 4'h2);
   wire [15:0]            push_data   = (entry_cnt == 4'h0) ? saved_pc : {8'h00, condition_code_reg};
   wire                   pop_en      = (state == pia_pkg::PIA_POP_PS) || (state == pia_pkg::PIA_POP_PC);
   wire [SP_W-1:0]        pop_addr    = SP_W'(sp + 1'b1);
   wire [15:0]            pop_data    = stack_mem[pop_addr];
   wire                   entry_end   = (state == pia_pkg::PIA_ENTRY) && (entry_cnt == ENTRY_LAST);
   wire [15:0]            vector_next = 16'(VECTOR_TOP - 16'(pia_pkg::VECTOR_STEP * 16'(best_idx)));
   wire [7:0]             level_byte  = (level_sel < 4'(NUM_REG)) ? src_levels[8*level_sel +: 8] : 8'h00;
   wire [31:0]            status_word = {14'h0, stack_err, entry_busy_o, 8'(best_idx), 6'h0, best_level};
   wire [31:0]            rd_mux      = hit_level  ? {24'h0, level_byte} :
                                        hit_flag   ? 32'(req_flag) :
                                        hit_enable ? 32'(req_en) :
                                        hit_ccr    ? {24'h0, condition_code_reg} :
                                        hit_status ? status_word : 32'h0;

   assign entry_busy_o = (state == pia_pkg::PIA_ENTRY);
   assign entry_done_o = entry_end;

   // Per-source effective level: a cleared flag or enable reads as no request
   for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
      assign eff_level[i] = (req_flag[i] && req_en[i]) ? src_levels[2*i +: 2]
                                                       : pia_pkg::LEVEL_NONE;
   end

   // Walking from the top index down with <= lets the lowest index win a tie
   always_comb begin
      best_level = pia_pkg::LEVEL_NONE;
      best_idx   = '0;
      for (int k = NUM_SRC - 1; k >= 0; k--) begin
         if (eff_level[k] != pia_pkg::LEVEL_NONE && eff_level[k] <= best_level) begin
            best_level = eff_level[k];
            best_idx   = IDX_W'(k);
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
      end else if (ce_i) begin
         wb_ack_o <= bus_req & ~wb_ack_o;
         if (bus_req && !wb_ack_o) begin
            wb_dat_o <= rd_mux;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         src_levels <= {NUM_REG{pia_pkg::LEVEL_RST}};
      end else if (ce_i && bus_wr && hit_level && wb_sel_i[0] && level_sel < 4'(NUM_REG)) begin
         src_levels[8*level_sel +: 8] <= wb_dat_i[7:0];
      end
   end

   // A fresh event beats a clear in the same cycle; acceptance never touches the flag
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         req_flag <= '0;
         req_en   <= '0;
      end else if (ce_i) begin
         req_flag <= (req_flag & ~flag_clr) | src_event_i;
         if (bus_wr && hit_enable) begin
            req_en <= (req_en & ~wr_mask) | (wb_dat_i[NUM_SRC-1:0] & wr_mask);
         end
      end
   end

   // Hardware updates beat a software write landing in the same cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         condition_code_reg <= pia_pkg::CCR_RST;
      end else if (ce_i) begin
         if (entry_end) begin
            condition_code_reg[pia_pkg::CCR_IL_LSB +: 2] <= acc_level;
         end else if (state == pia_pkg::PIA_POP_PS) begin
            condition_code_reg <= pop_data[7:0] & pia_pkg::CCR_MASK;
         end else if (ccr_sw_wr) begin
            condition_code_reg <= wb_dat_i[7:0] & pia_pkg::CCR_MASK;
         end
      end
   end

   // Nine entry cycles after an accept taken at most seventeen cycles late
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state     <= pia_pkg::PIA_IDLE;
         entry_cnt <= 4'h0;
         acc_level <= pia_pkg::LEVEL_NONE;
         acc_idx   <= '0;
         saved_pc  <= 16'h0;
      end else if (ce_i) begin
         case (state)
            pia_pkg::PIA_IDLE: begin
               entry_cnt <= 4'h0;
               if (accept) begin
                  state     <= pia_pkg::PIA_ENTRY;
                  acc_level <= best_level;
                  acc_idx   <= best_idx;
                  saved_pc  <= pc_i;
               end else if (ret_start) begin
                  state <= pia_pkg::PIA_POP_PS;
               end
            end
            pia_pkg::PIA_ENTRY: begin
               entry_cnt <= 4'(entry_cnt + 4'h1);
               if (entry_end) begin
                  state <= pia_pkg::PIA_IDLE;
               end
            end
            pia_pkg::PIA_POP_PS: state <= pia_pkg::PIA_POP_PC;
            pia_pkg::PIA_POP_PC: state <= pia_pkg::PIA_IDLE;
            default:             state <= pia_pkg::PIA_IDLE;
         endcase
      end
   end

   // Descending pushes and ascending pops; the pointer wraps but the error stays set
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sp        <= SP_TOP;
         stack_err <= 1'b0;
      end else if (ce_i) begin
         if (push_en) begin
            sp <= SP_W'(sp - 1'b1);
            if (sp == '0) begin
               stack_err <= 1'b1;
            end
         end else if (pop_en) begin
            sp <= pop_addr;
            if (sp == SP_TOP) begin
               stack_err <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (ce_i && push_en) begin
         stack_mem[sp] <= push_data;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         vector_addr_o <= 16'h0;
         pc_o          <= 16'h0;
         resume_o      <= 1'b0;
         wake_o        <= 1'b0;
         irq_level_o   <= pia_pkg::LEVEL_NONE;
      end else if (ce_i) begin
         resume_o    <= (state == pia_pkg::PIA_POP_PC);
         wake_o      <= standby_i & any_pend;
         irq_level_o <= best_level;
         if (accept) begin
            vector_addr_o <= vector_next;
         end
         if (state == pia_pkg::PIA_POP_PC) begin
            pc_o <= pop_data;
         end
      end
   end

   sequence s_entry_run;
      entry_busy_o [*8] ##1 entry_done_o;
   endsequence

   sequence s_return_pops;
      (state == pia_pkg::PIA_POP_PS) ##1 (state == pia_pkg::PIA_POP_PC) ##1 resume_o;
   endsequence

   chk_entry_nine_cycles: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
      accept |=> s_entry_run)
      else $error("entry sequence did not last nine cycles");

   chk_return_pop_order: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
      ret_start |=> s_return_pops)
      else $error("return did not pop status then PC");

   chk_accept_level_cond: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
      accept |-> (glob_en && best_level < cur_level && best_level != pia_pkg::LEVEL_NONE))
      else $error("accepted without priority or enable");

   chk_sample_last_cycle: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
      (state == pia_pkg::PIA_IDLE && $rose(entry_busy_o) == 1'b0 && !instr_end_i) |=> !entry_busy_o)
      else $error("request taken outside final instruction cycle");

   chk_level_loaded: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
      entry_done_o |=> (cur_level == $past(acc_level) && vector_addr_o == $past(vector_addr_o)))
      else $error("level field not loaded at end of entry");

   chk_flag_kept: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
      (accept && flag_clr[best_idx] == 1'b0) |=> req_flag[acc_idx])
      else $error("acceptance cleared the request flag");

   chk_event_sets_flag: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
      src_event_i[0] |=> req_flag[0])
      else $error("event did not set its flag");

   chk_stack_descends: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
      push_en |=> (sp == SP_W'($past(sp) - 1'b1)))
      else $error("push did not move the stack down");

   chk_wake_on_pending: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
      (standby_i && any_pend) |=> wake_o)
      else $error("pending request did not wake");

   chk_reset_disabled: assert property (@(posedge clk_i)
      $past(rst_i) |-> (src_levels == {NUM_REG{pia_pkg::LEVEL_RST}} && cur_level == pia_pkg::LEVEL_NONE))
      else $error("reset left a request enabled");

   chk_tie_lowest_wins: assert property (@(posedge clk_i) disable iff (rst_i)
      (eff_level[0] != pia_pkg::LEVEL_NONE && eff_level[0] == best_level) |-> best_idx == '0)
      else $error("request zero lost a tie");
endmodule : pia_ctrl

// File: dv/pia_core_model.sv
// Core-side partner model: instruction boundaries, program counter and return requests
`timescale 1ns/100ps
module pia_core_model #(
   parameter int INSTR_LEN = 12
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        busy_i,
   input  wire logic        ret_req_i,
   output logic             instr_end_o,
   output logic      [15:0] pc_o,
   output logic             ret_o
);
   int          cnt      = 0;
   logic [15:0] pc       = 16'h1000;
   logic        ret_pend = 1'b0;
   // Only the last cycle of an instruction ends it; entry itself is not an instruction
   assign instr_end_o = (cnt == INSTR_LEN - 1) && !busy_i;
   // Return issued mid-instruction, the cycle the core starts its return sequence
   assign ret_o       = ret_pend && !instr_end_o && !busy_i;
   assign pc_o        = pc;
   always @(posedge clk_i) begin
      if (rst_i) begin
         cnt      <= 0;
         pc       <= 16'h1000;
         ret_pend <= 1'b0;
      end else begin
         if (!busy_i) begin
            cnt <= (cnt == INSTR_LEN - 1) ? 0 : cnt + 1;
         end
         if (instr_end_o) begin
            pc <= pc + 16'h0001;
         end
         ret_pend <= ret_req_i | (ret_pend & !ret_o);
      end
   end
endmodule : pia_core_model

// File: dv/priority_interrupt_acceptance_tb_top.sv
// Self-checking bench for the priority interrupt acceptance block
`timescale 1ns/100ps
module priority_interrupt_acceptance_tb_top;
   typedef struct packed {
      logic [7:0] lvl;
      logic [3:0] en;
      logic [3:0] ev;
      logic [1:0] exp_lvl;
      logic [4:0] exp_idx;
   } pia_row_s;
   localparam pia_row_s ROWS [6] = '{
      '{8'hff, 4'hf, 4'hf, 2'h3, 5'h00}, '{8'h9b, 4'hf, 4'hf, 2'h1, 5'h02},
      '{8'h9b, 4'hb, 4'hf, 2'h2, 5'h01}, '{8'h00, 4'hf, 4'hc, 2'h0, 5'h02},
      '{8'h00, 4'hf, 4'h0, 2'h3, 5'h00}, '{8'h55, 4'h8, 4'hf, 2'h1, 5'h03}};
   logic        clk_i;
   logic        rst_i   = 1'b1;
   logic        cyc     = 1'b0;
   logic        stb     = 1'b0;
   logic        we      = 1'b0;
   logic        standby = 1'b0;
   logic        ret_req = 1'b0;
   logic [7:0]  adr     = 8'h00;
   logic [31:0] dat_w   = 32'h0;
   logic [23:0] ev      = 24'h0;
   logic [31:0] wb_dat_o, q;
   logic        wb_ack_o, instr_end, ret, irq_busy, done, resume, wake;
   logic [15:0] pc_i, pc_prev, vec, pc_o, pc1, pc2;
   logic [1:0]  irq_level;
   int          bad_count = 0;
   int          compares  = 0;
   int          cycles    = 0;
   int          l, b, n;

   pia_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat_w), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .src_event_i(ev), .instr_end_i(instr_end), .pc_i(pc_i), .ret_i(ret), .standby_i(standby),
      .irq_level_o(irq_level), .entry_busy_o(irq_busy), .entry_done_o(done), .vector_addr_o(vec),
      .pc_o(pc_o), .resume_o(resume), .wake_o(wake));
   pia_core_model #(.INSTR_LEN(12)) core (.clk_i(clk_i), .rst_i(rst_i), .busy_i(irq_busy),
      .ret_req_i(ret_req), .instr_end_o(instr_end), .pc_o(pc_i), .ret_o(ret));

   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   always @(posedge clk_i) pc_prev <= pc_i;
   // Generous ceiling: the whole sequence needs well under two thousand cycles
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : report_and_stop
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc   <= 1'b1;
      stb   <= 1'b1;
      we    <= w;
      adr   <= a;
      dat_w <= d;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : bus
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
      bus(1'b0, a, 32'h0);
      chk(nm, q & m, e);
   endtask : rd_chk
   task automatic pulse(input logic [23:0] e);
      @(posedge clk_i);
      ev <= e;
      @(posedge clk_i);
      ev <= 24'h0;
   endtask : pulse
   // Counts edges until entry starts, then the entry cycles themselves
   task automatic wait_entry();
      l = 0;
      b = 0;
      do begin @(posedge clk_i); l++; end while (irq_busy !== 1'b1);
      while (irq_busy === 1'b1) begin @(posedge clk_i); b++; end
   endtask : wait_entry
   task automatic do_ret(input logic [15:0] exp_pc, input logic [31:0] exp_ccr);
      @(posedge clk_i);
      ret_req <= 1'b1;
      @(posedge clk_i);
      ret_req <= 1'b0;
      do @(posedge clk_i); while (resume !== 1'b1);
      chk("return pc", {16'h0, pc_o}, {16'h0, exp_pc});
      rd_chk(8'h48, 32'hff, exp_ccr, "ccr after return");
   endtask : do_ret
   task automatic reset_checks();
      rd_chk(8'h00, 32'hff, 32'hff, "level reg reset");
      rd_chk(8'h48, 32'hff, 32'h03, "ccr reset");
      rd_chk(8'h44, 32'hffffffff, 32'h0, "enables reset");
      rd_chk(8'h80, 32'hffffffff, 32'h0, "unmapped read");
      chk("level out reset", {30'h0, irq_level}, 32'h3);
   endtask : reset_checks

   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      reset_checks();
      standby <= 1'b1;
      foreach (ROWS[i]) begin
         bus(1'b1, 8'h40, 32'h0);
         bus(1'b1, 8'h44, {28'h0, ROWS[i].en});
         bus(1'b1, 8'h00, {24'h0, ROWS[i].lvl});
         pulse({20'h0, ROWS[i].ev});
         repeat (4) @(posedge clk_i);
         chk("best level", {30'h0, irq_level}, {30'h0, ROWS[i].exp_lvl});
         rd_chk(8'h4c, (ROWS[i].exp_lvl == 2'h3) ? 32'h3 : 32'h1f03,
                {19'h0, ROWS[i].exp_idx, 6'h0, ROWS[i].exp_lvl}, "status");
         chk("wake", {31'h0, wake}, {31'h0, ROWS[i].exp_lvl != 2'h3});
      end
      standby <= 1'b0;
      bus(1'b1, 8'h40, 32'h0);
      // The last row left only source 3 enabled; the nesting sources need theirs back
      bus(1'b1, 8'h44, 32'h00ffffff);
      bus(1'b1, 8'h00, 32'h9b);
      bus(1'b1, 8'h48, 32'h13);
      pulse(24'h4);
      wait_entry();
      // The core stepped its PC in the accepting cycle, so the stacked value is one behind
      pc1 = pc_prev - 16'h1;
      chk("entry cycles", b, pia_pkg::ENTRY_CYCLES);
      chk("latency bound", {31'h0, l + b <= pia_pkg::MAX_LATENCY}, 32'h1);
      chk("vector", {16'h0, vec}, 32'hfff8);
      rd_chk(8'h48, 32'hff, 32'h11, "ccr in service");
      rd_chk(8'h40, 32'h4, 32'h4, "flag kept");
      n = 0;
      // Same level as the one in service must wait
      repeat (30) begin
         @(posedge clk_i);
         if (irq_busy === 1'b1) n++;
      end
      chk("no equal nest", n, 0);
      bus(1'b1, 8'h00, 32'h98);
      pulse(24'h1);
      wait_entry();
      pc2 = pc_prev - 16'h1;
      chk("nest vector", {16'h0, vec}, 32'hfffc);
      rd_chk(8'h48, 32'hff, 32'h10, "ccr nested");
      bus(1'b1, 8'h40, 32'h0);
      do_ret(pc2, 32'h11);
      do_ret(pc1, 32'h13);
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      reset_checks();
      report_and_stop();
   end
endmodule : priority_interrupt_acceptance_tb_top
